// ---- inc/uhp_pkg.sv ----
// shared constants, types and state codes for the upconverter input port
package uhp_pkg;
	// sample bus
	localparam int SAMPLE_W  = 14;
	localparam int SIGN_BIT  = SAMPLE_W - 1;
	localparam int PROFILE_W = 2;
	typedef logic signed [SAMPLE_W-1:0] uhp_sample_t;

	// serial frame: instruction byte (read flag, address) then one data byte
	localparam int          BYTE_W      = 8;
	localparam int          FRAME_BITS  = 16;
	localparam int          ADDR_W      = 5;
	localparam int          REG_IDX_W   = 2;
	localparam int          REG_COUNT   = 4;
	localparam int          RW_BIT      = 7;
	localparam logic [2:0]  LAST_BIT    = 3'h7;
	localparam logic [2:0]  FIRST_BIT   = 3'h0;
	localparam logic [7:0]  REG_RESET   = 8'h00;
	localparam int          CTRL_IDX    = 0;
	localparam int          CTRL_INPUT_ONLY_BIT = 7;
	localparam int          CTRL_INTERP_BIT     = 0;
	localparam logic [7:0]  UNMAPPED_READ = 8'h00;

	// controller clocking: serial clock half period in system clock cycles
	localparam int          SYS_CLK_MHZ    = 40;
	localparam int          SCLK_MAX_MHZ   = 10;
	localparam logic [2:0]  SCLK_HALF      = 3'h4;
	localparam logic [3:0]  FRAME_LAST     = 4'hF;
	localparam logic [3:0]  READ_TURN      = 4'h7;

	// controller apb map
	localparam logic [11:0] APB_CTRL   = 12'h000;
	localparam logic [11:0] APB_SAMPLE = 12'h004;
	localparam logic [11:0] APB_CMD    = 12'h008;
	localparam logic [11:0] APB_STATUS = 12'h00C;
	localparam int          AC_GATE       = 0;
	localparam int          AC_PROF_LSB   = 1;
	localparam int          AC_RESYNC     = 3;
	localparam int          AC_INPUT_ONLY = 4;
	localparam int          AS_Q_LSB      = 16;
	localparam int          CMD_READ_BIT  = 15;
	localparam int          STAT_BUSY_BIT = 8;

	typedef enum logic [1:0]
	{
		S_INSTR = 2'h0,
		S_WDATA = 2'h1,
		S_RDATA = 2'h3,
		S_DONE  = 2'h2
	} uhp_dev_state_t;

	typedef enum logic [1:0]
	{
		H_IDLE = 2'h0,
		H_LOW  = 2'h1,
		H_HIGH = 2'h3,
		H_END  = 2'h2
	} uhp_host_state_t;
endpackage

// ---- inc/uhp_link_if.sv ----
// pins between the host controller and the upconverter input port
`timescale 1ns/1ps
interface uhp_link_if;
	import uhp_pkg::*;
	logic                   cs_n;
	logic                   sclk;
	logic                   serial_port_resync;
	logic                   sdio_h_o;
	logic                   sdio_h_oe;
	logic                   sdio_d_o;
	logic                   sdio_d_oe;
	logic                   serial_out_line_o;
	logic                   serial_out_line_oe;
	logic                   sdio;
	logic                   serial_out_line;
	logic [SAMPLE_W-1:0]    parallel_sample_bus;
	logic                   transmit_gate;
	logic                   profile_select_high;
	logic                   profile_select_low;

	// pulled-up wires; released lines read high
	assign sdio = sdio_h_oe ? sdio_h_o : (sdio_d_oe ? sdio_d_o : 1'h1);
	assign serial_out_line = serial_out_line_oe ? serial_out_line_o : 1'h1;

	modport host
	(
		output cs_n, sclk, serial_port_resync, sdio_h_o, sdio_h_oe,
		output parallel_sample_bus, transmit_gate, profile_select_high, profile_select_low,
		input  sdio, serial_out_line
	);
	modport dev
	(
		input  cs_n, sclk, serial_port_resync, sdio,
		input  parallel_sample_bus, transmit_gate, profile_select_high, profile_select_low,
		output sdio_d_o, sdio_d_oe, serial_out_line_o, serial_out_line_oe
	);
endinterface

// ---- src/uhp_device.sv ----
// device end: sample demultiplexer, profile decode and serial control port
// Functional notes
// - samples are 14-bit twos complement, top bit sign
// - normal mode: accepted words alternate I then Q
// - interpolating mode: every accepted word goes to I
// - gate rising: next word is I, then alternate
// - two select pins pick one of four profiles
// - serial port acts only while chip select low
// - data line bidirectional, input-only via control bit 7
// - separate output drives only in input-only mode
// - resync aborts transfer, registers keep their contents
// - host supplies serial clock; serial logic uses it
`timescale 1ns/1ps
module uhp_device
	import uhp_pkg::*;
(
	input  wire logic                  i_clock,
	input  wire logic                  i_reset,
	uhp_link_if.dev                    link,
	output uhp_sample_t                o_i_word,
	output logic                       o_i_valid,
	output uhp_sample_t                o_q_word,
	output logic                       o_q_valid,
	output logic [PROFILE_W-1:0]       o_profile,
	output logic                       o_interp_mode,
	output logic                       o_sdio_input_only
);
	// serial clock domain
	uhp_dev_state_t       st_q, st_d;
	logic [2:0]           cnt_q, cnt_d;
	logic [BYTE_W-1:0]    sh_q, sh_d;
	logic [BYTE_W-1:0]    instr_q, instr_d;
	logic [BYTE_W-1:0]    regs_q [REG_COUNT];
	logic [BYTE_W-1:0]    regs_d [REG_COUNT];
	logic [BYTE_W-1:0]    rd_byte;
	logic                 addr_ok;
	logic                 out_q, out_d;
	logic                 oe_q, oe_d;
	logic                 frame_rst;
	logic                 input_only;

	// the frame state dies with chip select or resync, since sclk stops between frames
	assign frame_rst  = i_reset | link.cs_n | link.serial_port_resync;
	assign addr_ok    = (instr_q[ADDR_W-1:REG_IDX_W] == '0);
	assign rd_byte    = addr_ok ? regs_q[instr_q[REG_IDX_W-1:0]] : UNMAPPED_READ;
	assign input_only = regs_q[CTRL_IDX][CTRL_INPUT_ONLY_BIT];

	always_comb
	begin
		st_d    = st_q;
		cnt_d   = cnt_q + 3'h1;
		sh_d    = {sh_q[BYTE_W-2:0], link.sdio};
		instr_d = instr_q;
		regs_d  = regs_q;
		unique case (st_q)
			S_INSTR:
			begin
				if (cnt_q == LAST_BIT)
				begin
					instr_d = sh_d;
					st_d    = sh_d[RW_BIT] ? S_RDATA : S_WDATA;
				end
			end
			S_WDATA:
			begin
				if (cnt_q == LAST_BIT)
				begin
					if (addr_ok)
					begin
						regs_d[instr_q[REG_IDX_W-1:0]] = sh_d;
					end
					st_d = S_DONE;
				end
			end
			S_RDATA:
			begin
				if (cnt_q == LAST_BIT)
				begin
					st_d = S_DONE;
				end
			end
			S_DONE:
			begin
				cnt_d = cnt_q;
			end
		endcase
	end

	// register contents reset only by the chip reset, so resync leaves them alone
	always_ff @(posedge link.sclk or posedge i_reset)
	begin
		if (i_reset)
		begin
			for (int i = 0; i < REG_COUNT; i++)
			begin
				regs_q[i] <= REG_RESET;
			end
		end
		else
		begin
			regs_q <= regs_d;
		end
	end

	always_ff @(posedge link.sclk or posedge frame_rst)
	begin
		if (frame_rst)
		begin
			st_q    <= S_INSTR;
			cnt_q   <= FIRST_BIT;
			sh_q    <= REG_RESET;
			instr_q <= REG_RESET;
		end
		else
		begin
			st_q    <= st_d;
			cnt_q   <= cnt_d;
			sh_q    <= sh_d;
			instr_q <= instr_d;
		end
	end

	always_comb
	begin
		oe_d  = (st_q == S_RDATA);
		out_d = oe_d ? rd_byte[LAST_BIT - cnt_q] : out_q;
	end

	always_ff @(negedge link.sclk or posedge frame_rst)
	begin
		if (frame_rst)
		begin
			out_q <= 1'h0;
			oe_q  <= 1'h0;
		end
		else
		begin
			out_q <= out_d;
			oe_q  <= oe_d;
		end
	end

	assign link.sdio_d_o           = out_q;
	assign link.sdio_d_oe          = oe_q & ~input_only;
	assign link.serial_out_line_o  = out_q;
	assign link.serial_out_line_oe = oe_q & input_only;

	// system clock domain: pins and control bits pass two flip-flops
	localparam int PIN_W = SAMPLE_W + 5;
	logic [PIN_W-1:0]     pin_s1_q, pin_s2_q;
	uhp_sample_t          smp;
	logic                 gate, interp;
	logic                 gate_prev_q, phase_q, phase_d, ph;
	uhp_sample_t          i_word_d, q_word_d;
	logic                 i_valid_d, q_valid_d;

	assign smp    = uhp_sample_t'(pin_s2_q[SAMPLE_W-1:0]);
	assign gate   = pin_s2_q[SAMPLE_W];
	assign interp = pin_s2_q[SAMPLE_W+3];

	always_comb
	begin
		ph        = (gate & ~gate_prev_q) ? 1'h0 : phase_q;
		phase_d   = phase_q;
		i_word_d  = o_i_word;
		q_word_d  = o_q_word;
		i_valid_d = 1'h0;
		q_valid_d = 1'h0;
		if (gate)
		begin
			if (interp || !ph)
			begin
				i_word_d  = smp;
				i_valid_d = 1'h1;
			end
			else
			begin
				q_word_d  = smp;
				q_valid_d = 1'h1;
			end
			phase_d = interp ? 1'h0 : ~ph;
		end
	end

	always_ff @(posedge i_clock or posedge i_reset)
	begin
		if (i_reset)
		begin
			pin_s1_q          <= '0;
			pin_s2_q          <= '0;
			gate_prev_q       <= 1'h0;
			phase_q           <= 1'h0;
			o_i_word          <= '0;
			o_q_word          <= '0;
			o_i_valid         <= 1'h0;
			o_q_valid         <= 1'h0;
			o_profile         <= '0;
			o_interp_mode     <= 1'h0;
			o_sdio_input_only <= 1'h0;
		end
		else
		begin
			pin_s1_q <= {input_only, regs_q[CTRL_IDX][CTRL_INTERP_BIT],
				link.profile_select_high, link.profile_select_low,
				link.transmit_gate, link.parallel_sample_bus};
			pin_s2_q          <= pin_s1_q;
			gate_prev_q       <= gate;
			phase_q           <= phase_d;
			o_i_word          <= i_word_d;
			o_q_word          <= q_word_d;
			o_i_valid         <= i_valid_d;
			o_q_valid         <= q_valid_d;
			o_profile         <= pin_s2_q[SAMPLE_W+2:SAMPLE_W+1];
			o_interp_mode     <= interp;
			o_sdio_input_only <= pin_s2_q[SAMPLE_W+4];
		end
	end
endmodule

// ---- src/uhp_host.sv ----
// host end: apb-programmed controller driving samples, profile pins and serial port
//
// The placing of the registers and register access over APB were left to the implementer.
`timescale 1ns/1ps
module uhp_host
	import uhp_pkg::*;
(
	input  wire logic                  i_clock,
	input  wire logic                  i_reset,
	input  wire logic                  i_psel,
	input  wire logic                  i_penable,
	input  wire logic                  i_pwrite,
	input  wire logic [11:0]           i_paddr,
	input  wire logic [31:0]           i_pwdata,
	output logic      [31:0]           o_prdata,
	output logic                       o_pready,
	output logic                       o_pslverr,
	uhp_link_if.host                   link
);
	logic [31:0]          ctrl_q, ctrl_d, smp_q, smp_d, prdata_d;
	logic                 pready_d, wr, start;
	uhp_host_state_t      st_q, st_d;
	logic [2:0]           half_q, half_d;
	logic [3:0]           bit_q, bit_d;
	logic [FRAME_BITS-1:0] sh_q, sh_d;
	logic                 rd_q, rd_d, busy_q, busy_d;
	logic [BYTE_W-1:0]    rx_q, rx_d, rdata_q, rdata_d;
	logic                 cs_n_q, cs_n_d, sclk_q, sclk_d, sdo_q, sdo_d, oe_q, oe_d;
	logic                 rx_s1_q, rx_s2_q, phase_q, phase_d, gate_prev_q;
	logic [SAMPLE_W-1:0]  bus_q, bus_d;

	// one wait state so that pready and prdata come from flip-flops
	assign wr    = i_psel & i_penable & o_pready & i_pwrite;
	assign start = wr & (i_paddr == APB_CMD) & ~busy_q;

	always_comb
	begin
		pready_d = i_psel & i_penable & ~o_pready;
		ctrl_d   = ctrl_q;
		smp_d    = smp_q;
		if (wr && i_paddr == APB_CTRL)
		begin
			ctrl_d = i_pwdata;
		end
		if (wr && i_paddr == APB_SAMPLE)
		begin
			smp_d = i_pwdata;
		end
		unique case (i_paddr)
			APB_CTRL:   prdata_d = ctrl_q;
			APB_SAMPLE: prdata_d = smp_q;
			APB_STATUS: prdata_d = {23'h0, busy_q, rdata_q};
			default:    prdata_d = 32'h0;
		endcase
	end

	// host orders I then Q, restarting at I whenever the gate rises
	always_comb
	begin
		// phase 0 marks an I word on the bus, so the word after a gate rise is I
		phase_d = (ctrl_q[AC_GATE] & ~gate_prev_q) ? 1'h0 : ~phase_q;
		bus_d   = phase_d ? smp_q[AS_Q_LSB+SAMPLE_W-1:AS_Q_LSB] : smp_q[SAMPLE_W-1:0];
		if (ctrl_q[AC_GATE] & ~gate_prev_q)
		begin
			bus_d = smp_q[SAMPLE_W-1:0];
		end
	end

	always_comb
	begin
		st_d    = st_q;
		half_d  = half_q + 3'h1;
		bit_d   = bit_q;
		sh_d    = sh_q;
		rd_d    = rd_q;
		busy_d  = busy_q;
		rx_d    = rx_q;
		rdata_d = rdata_q;
		cs_n_d  = cs_n_q;
		sclk_d  = sclk_q;
		sdo_d   = sdo_q;
		oe_d    = oe_q;
		unique case (st_q)
			H_IDLE:
			begin
				half_d = '0;
				if (start)
				begin
					sh_d   = i_pwdata[FRAME_BITS-1:0];
					rd_d   = i_pwdata[CMD_READ_BIT];
					sdo_d  = i_pwdata[FRAME_BITS-1];
					bit_d  = '0;
					busy_d = 1'h1;
					cs_n_d = 1'h0;
					oe_d   = 1'h1;
					st_d   = H_LOW;
				end
			end
			H_LOW:
			begin
				if (half_d == SCLK_HALF)
				begin
					half_d = '0;
					sclk_d = 1'h1;
					st_d   = H_HIGH;
				end
			end
			H_HIGH:
			begin
				if (half_d == SCLK_HALF)
				begin
					half_d = '0;
					sclk_d = 1'h0;
					if (rd_q && bit_q > READ_TURN)
					begin
						rx_d = {rx_q[BYTE_W-2:0], rx_s2_q};
					end
					if (bit_q == FRAME_LAST)
					begin
						st_d = H_END;
					end
					else
					begin
						bit_d = bit_q + 4'h1;
						sh_d  = {sh_q[FRAME_BITS-2:0], 1'h0};
						sdo_d = sh_q[FRAME_BITS-2];
						oe_d  = ~(rd_q && bit_q >= READ_TURN);
						st_d  = H_LOW;
					end
				end
			end
			H_END:
			begin
				if (half_d == SCLK_HALF)
				begin
					cs_n_d  = 1'h1;
					oe_d    = 1'h0;
					busy_d  = 1'h0;
					rdata_d = rx_q;
					st_d    = H_IDLE;
				end
			end
		endcase
		if (ctrl_q[AC_RESYNC])
		begin
			st_d   = H_IDLE;
			cs_n_d = 1'h1;
			sclk_d = 1'h0;
			oe_d   = 1'h0;
			busy_d = 1'h0;
		end
	end

	always_ff @(posedge i_clock or posedge i_reset)
	begin
		if (i_reset)
		begin
			o_prdata <= '0;
			o_pready <= 1'h0;
			ctrl_q   <= '0;
			smp_q    <= '0;
			st_q     <= H_IDLE;
			half_q   <= '0;
			bit_q    <= '0;
			sh_q     <= '0;
			rd_q     <= 1'h0;
			busy_q   <= 1'h0;
			rx_q     <= '0;
			rdata_q  <= '0;
			cs_n_q   <= 1'h1;
			sclk_q   <= 1'h0;
			sdo_q    <= 1'h0;
			oe_q     <= 1'h0;
			rx_s1_q  <= 1'h1;
			rx_s2_q  <= 1'h1;
			phase_q  <= 1'h1;
			gate_prev_q <= 1'h0;
			bus_q    <= '0;
		end
		else
		begin
			o_prdata <= prdata_d;
			o_pready <= pready_d;
			ctrl_q   <= ctrl_d;
			smp_q    <= smp_d;
			st_q     <= st_d;
			half_q   <= half_d;
			bit_q    <= bit_d;
			sh_q     <= sh_d;
			rd_q     <= rd_d;
			busy_q   <= busy_d;
			rx_q     <= rx_d;
			rdata_q  <= rdata_d;
			cs_n_q   <= cs_n_d;
			sclk_q   <= sclk_d;
			sdo_q    <= sdo_d;
			oe_q     <= oe_d;
			rx_s1_q  <= ctrl_q[AC_INPUT_ONLY] ? link.serial_out_line : link.sdio;
			rx_s2_q  <= rx_s1_q;
			phase_q  <= phase_d;
			gate_prev_q <= ctrl_q[AC_GATE];
			bus_q    <= bus_d;
		end
	end

	assign o_pslverr                = 1'h0;
	assign link.cs_n                = cs_n_q;
	assign link.sclk                = sclk_q;
	assign link.sdio_h_o            = sdo_q;
	assign link.sdio_h_oe           = oe_q;
	assign link.serial_port_resync  = ctrl_q[AC_RESYNC];
	assign link.parallel_sample_bus = bus_q;
	assign link.transmit_gate       = gate_prev_q;
	assign link.profile_select_high = ctrl_q[AC_PROF_LSB+1];
	assign link.profile_select_low  = ctrl_q[AC_PROF_LSB];
endmodule

// ---- sim/uhp_link_assertions.sv ----
// concurrent checks on the serial link between the host and device ends
`timescale 1ns/1ps
module uhp_link_assertions
(
	input  wire logic i_clock,
	input  wire logic i_reset,
	input  wire logic cs_n,
	input  wire logic sclk,
	input  wire logic serial_port_resync,
	input  wire logic sdio_d_o,
	input  wire logic sdio_d_oe,
	input  wire logic serial_out_line_o,
	input  wire logic serial_out_line_oe
);
	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (i_reset);

	// frame logic is cleared asynchronously, so one settled cycle is enough
	desel_quiet_a: assert property (cs_n && $past(cs_n)
		|-> !sdio_d_oe && !serial_out_line_oe)
		else $error("device drives a line while deselected");
	one_driver_a: assert property (!(sdio_d_oe && serial_out_line_oe))
		else $error("both device outputs driven at once");
	resync_quiet_a: assert property (serial_port_resync && $past(serial_port_resync)
		|-> !sdio_d_oe && !serial_out_line_oe)
		else $error("device drives a line during resync");
	sclk_idle_a: assert property (cs_n && $past(cs_n) |-> !sclk)
		else $error("serial clock runs outside a frame");
	// a resync may cut a high phase short, so it is left out of this check
	sclk_high_a: assert property (disable iff (i_reset || serial_port_resync)
		$rose(sclk) |-> sclk[*4] ##1 !sclk)
		else $error("serial clock high phase has wrong length");
	drive_at_fall_a: assert property ($rose(sdio_d_oe || serial_out_line_oe)
		|-> !sclk)
		else $error("device output enabled outside a falling edge");
	sdio_stable_a: assert property (sclk && $past(sclk) && sdio_d_oe
		|-> $stable(sdio_d_o))
		else $error("shared data line changes while clock high");
	sdo_stable_a: assert property (sclk && $past(sclk) && serial_out_line_oe
		|-> $stable(serial_out_line_o))
		else $error("separate output changes while clock high");
endmodule

// ---- sim/upconverter_host_input_port_tb_top.sv ----
// testbench: apb-driven host end against the device end
`timescale 1ns/1ps
module upconverter_host_input_port_tb_top
	import uhp_pkg::*;
;
	localparam uhp_sample_t IV = 14'h2001;
	localparam uhp_sample_t QV = 14'h1FFE;
	logic                 i_clock = 1'h0;
	logic                 i_reset = 1'h1;
	logic                 psel    = 1'h0;
	logic                 penable = 1'h0;
	logic                 pwrite  = 1'h0;
	logic [11:0]          paddr   = 12'h000;
	logic [31:0]          pwdata  = 32'h00000000;
	logic [31:0]          prdata;
	logic                 pready;
	uhp_sample_t          i_word;
	uhp_sample_t          q_word;
	logic                 i_valid;
	logic                 q_valid;
	logic [PROFILE_W-1:0] profile;
	logic                 interp;
	logic                 input_only;
	int                   n_mismatch = 0;
	int                   n_tests = 0;

	uhp_link_if link();
	uhp_host i_uhp_host (.i_clock(i_clock), .i_reset(i_reset), .i_psel(psel),
		.i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
		.o_prdata(prdata), .o_pready(pready), .o_pslverr(), .link(link));
	uhp_device i_uhp_device (.i_clock(i_clock), .i_reset(i_reset), .link(link),
		.o_i_word(i_word), .o_i_valid(i_valid), .o_q_word(q_word), .o_q_valid(q_valid),
		.o_profile(profile), .o_interp_mode(interp), .o_sdio_input_only(input_only));
	uhp_link_assertions i_uhp_link_assertions (.i_clock(i_clock), .i_reset(i_reset),
		.cs_n(link.cs_n), .sclk(link.sclk), .serial_port_resync(link.serial_port_resync),
		.sdio_d_o(link.sdio_d_o), .sdio_d_oe(link.sdio_d_oe),
		.serial_out_line_o(link.serial_out_line_o),
		.serial_out_line_oe(link.serial_out_line_oe));

	always #12.5 i_clock = ~i_clock;

	task automatic print_verdict();
		if (n_mismatch == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic give_up();
		n_mismatch++;
		$display("wrong value at %0t: no answer in time", $time);
		print_verdict();
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	// values read just after an edge are those the slave showed at that edge
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r);
		int n;
		n = 0;
		@(posedge i_clock);
		psel <= 1'h1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge i_clock);
		penable <= 1'h1;
		@(posedge i_clock);
		while (pready !== 1'h1)
		begin
			n++;
			if (n > 50)
				give_up();
			@(posedge i_clock);
		end
		r = prdata;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		apb(1'h1, a, d, r);
	endtask

	task automatic ser(input logic rd, input logic [4:0] a, input logic [7:0] d,
		output logic [7:0] b);
		logic [31:0] s;
		int n;
		wr(APB_CMD, {16'h0000, rd, 2'h0, a, d});
		n = 0;
		s = 32'h00000100;
		while (s[STAT_BUSY_BIT] !== 1'h0)
		begin
			n++;
			if (n > 100)
				give_up();
			apb(1'h0, APB_STATUS, 32'h00000000, s);
		end
		b = s[7:0];
	endtask

	task automatic wait_word(output logic isq, output uhp_sample_t w);
		int n;
		n = 0;
		@(negedge i_clock);
		while (!(i_valid === 1'h1 || q_valid === 1'h1))
		begin
			n++;
			if (n > 40)
				give_up();
			@(negedge i_clock);
		end
		isq = q_valid;
		w = q_valid ? q_word : i_word;
	endtask

	initial
	begin
		logic [7:0]  b;
		logic        isq;
		uhp_sample_t w;
		int          ni;
		int          nq;
		repeat (2) @(posedge i_clock);
		i_reset <= 1'h0;
		@(negedge i_clock);
		check(input_only, 1'h0);
		check(link.serial_out_line_oe, 1'h0);
		for (int p = 0; p < 4; p++)
		begin
			wr(APB_CTRL, 32'(p) << AC_PROF_LSB);
			repeat (5) @(negedge i_clock);
			check({link.profile_select_high, link.profile_select_low}, p);
			check(profile, p);
		end
		wr(APB_CTRL, 32'h00000000);
		ser(1'h0, 5'h01, 8'hA5, b);
		ser(1'h1, 5'h01, 8'h00, b);
		check(b, 8'hA5);
		ser(1'h1, 5'h1F, 8'h00, b);
		check(b, UNMAPPED_READ);
		// resync cuts this write before its last bit, so the old value must stay
		wr(APB_CMD, {16'h0000, 1'h0, 2'h0, 5'h01, 8'h3C});
		wr(APB_CTRL, 32'h00000001 << AC_RESYNC);
		ser(1'h1, 5'h01, 8'h00, b);
		wr(APB_CTRL, 32'h00000000);
		ser(1'h1, 5'h01, 8'h00, b);
		check(b, 8'hA5);
		ser(1'h0, 5'h00, 8'h80, b);
		check(input_only, 1'h1);
		wr(APB_CTRL, 32'h00000001 << AC_INPUT_ONLY);
		ser(1'h1, 5'h01, 8'h00, b);
		check(b, 8'hA5);
		wr(APB_CTRL, 32'h00000000);
		ser(1'h0, 5'h00, 8'h00, b);
		wr(APB_SAMPLE, {2'h0, QV, 2'h0, IV});
		wr(APB_CTRL, 32'h00000001);
		wait_word(isq, w);
		check(isq, 1'h0);
		check(w, IV);
		wait_word(isq, w);
		check(isq, 1'h1);
		check(w, QV);
		wait_word(isq, w);
		check(isq, 1'h0);
		wr(APB_CTRL, 32'h00000000);
		ser(1'h0, 5'h00, 8'h01, b);
		check(interp, 1'h1);
		wr(APB_CTRL, 32'h00000001);
		ni = 0;
		nq = 0;
		repeat (20)
		begin
			@(negedge i_clock);
			ni += (i_valid === 1'h1);
			nq += (q_valid === 1'h1);
		end
		check(nq, 0);
		check(ni > 10, 1'h1);
		wr(APB_CTRL, 32'h00000000);
		print_verdict();
	end
endmodule
